/* sti_table_access.sv */
// indirect access to multicast, vlan and per-port acl tables over wishbone
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
module sti_table_access
   import sti_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [15:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatWr,
   output logic [31:0] wbDatRd,
   output logic wbAck,
   input wire logic lkReq,
   input wire logic [VLAN_IDX_W-1:0] lkVid,
   input wire logic [47:0] lkDa,
   output logic lkValid,
   output logic lkUseMap,
   output logic [7:0] lkFwdMap,
   output logic [7:0] lkUntag,
   output logic [2:0] lkPrio,
   output logic [2:0] lkSpanIdx,
   output logic [6:0] lkFid,
   output logic [11:0] lkHash,
   output logic vlanAware
);
   sti_state_t st_r;
   sti_state_t st_nxt;
   logic take;
   logic wrTake;
   logic aclHit;
   logic [2:0] aclSel;
   logic lkGo;
   logic vlanGo;
   logic [VLAN_IDX_W-1:0] vlanRamAddr;
   sti_vlan_t vlanRamRd;
   logic [VLAN_W-1:0] vlanRamRdRaw;
   logic [31:0] mcastMem [MCAST_ENTRIES];
   logic [31:0] mcastRdWord;
   logic aclBusy;
   logic aclWe;
   logic [6:0] aclAddr;
   logic [ACL_BYTES-1:0] aclByteEn;
   logic [ACL_BYTES-1:0][7:0] aclRdByte;
   logic [31:0] rd;
   logic [31:0] word;

   // vlan entry 0 as seen by software
   function automatic logic [31:0] vlanWord0(input sti_vlan_t e);
      return (32'(e.filter_identifier) << VE0_FID_LSB) | (32'(e.spanIdx) << VE0_SPAN_LSB)
         | (32'(e.prio) << VE0_PRIO_LSB) | (32'(e.fwdOpt) << VE0_FWDOPT_BIT)
         | (32'(e.valid) << VE0_VALID_BIT);
   endfunction

   // bus handshake and address decode
   assign take = wbCyc & wbStb & ~st_r.ack;
   assign wrTake = take & wbWe;
   assign aclHit = (wbAdr[15:12] >= 4'h1) && (wbAdr[15:12] <= 4'(ACL_PORT_CNT));
   assign aclSel = 3'(wbAdr[14:12] - 3'h1);

   // lookup owns the vlan ram port; software waits for a free cycle
   assign lkGo = lkReq & st_r.lookupEn;
   assign vlanGo = st_r.vlanStart & ~st_r.vlanRdPend & ~lkGo;
   assign vlanRamAddr = lkGo ? lkVid : st_r.vlanIdx;
   assign vlanRamRd = sti_vlan_t'(vlanRamRdRaw);

   sti_vlan_ram #(
      .DEPTH(VLAN_DEPTH),
      .AW(VLAN_IDX_W),
      .DW(VLAN_W)
   ) u_vlan_ram (
      .clk_sys(clk_sys),
      .we(vlanGo & ~st_r.vlanRead),
      .addr(vlanRamAddr),
      .wrData(VLAN_W'(st_r.vlanEntry)),
      .rdData(vlanRamRdRaw)
   );

   // multicast forwarding table
   assign mcastRdWord = mcastMem[st_r.mcastIdx];
   always_ff @(posedge clk_sys)
   begin
      if (st_r.mcastStart && !st_r.mcastRead)
         mcastMem[st_r.mcastIdx] <= st_r.mcastData;
   end

   // acl tables of all ports, one storage array per data byte except the unused byte 12
   assign aclBusy = (st_r.aclState == ACL_BUSY);
   assign aclWe = aclBusy & st_r.aclWrDir[st_r.aclPort];
   assign aclAddr = 7'(st_r.aclPort) * 7'(ACL_ENTRIES) + 7'(st_r.aclIdx[st_r.aclPort]);
   genvar gb;
   generate
      for (gb = 0; gb < ACL_BYTES; gb++)
      begin : g_acl_byte
         if (gb == ACL_UNUSED_BYTE)
         begin : g_unused
            assign aclByteEn[gb] = 1'b0;
            assign aclRdByte[gb] = 8'h00;
         end
         else
         begin : g_used
            logic [7:0] mem [ACL_PORT_CNT*ACL_ENTRIES];
            assign aclByteEn[gb] = st_r.aclBe[st_r.aclPort][ACL_BYTES-1-gb];
            assign aclRdByte[gb] = mem[aclAddr];
            always_ff @(posedge clk_sys)
            begin
               if (aclWe && aclByteEn[gb])
                  mem[aclAddr] <= st_r.aclData[st_r.aclPort][gb];
            end
         end
      end
   endgenerate

   // register read mux
   always_comb
   begin
      rd = 32'h0000_0000;
      case (wbAdr)
         VLAN_ENTRY0_OFS: rd = vlanWord0(st_r.vlanEntry);
         VLAN_ENTRY1_OFS: rd = {24'h000000, st_r.vlanEntry.untag};
         VLAN_ENTRY2_OFS: rd = {24'h000000, st_r.vlanEntry.member};
         VLAN_INDEX_OFS: rd = 32'(st_r.vlanIdx);
         VLAN_ACCESS_OFS: rd = 32'({st_r.vlanStart, 6'h00, st_r.vlanRead});
         LOOKUP_CTRL_OFS: rd = 32'(st_r.lookupEn);
         MCAST_CTRL_OFS: rd = 32'({st_r.mcastStart, st_r.mcastRead, st_r.mcastIdx});
         MCAST_DATA_OFS: rd = st_r.mcastData;
         default:
         begin
            if (aclHit && wbAdr[11:6] == ACL_DATA_OFS[11:6])
               rd = 32'(st_r.aclData[aclSel][wbAdr[5:2]]);
            else if (aclHit && wbAdr[11:0] == ACL_BE_MSB_OFS)
               rd = 32'(st_r.aclBe[aclSel][15:8]);
            else if (aclHit && wbAdr[11:0] == ACL_BE_LSB_OFS)
               rd = 32'(st_r.aclBe[aclSel][7:0]);
            else if (aclHit && wbAdr[11:0] == ACL_CTRL_OFS)
               rd = 32'({st_r.aclWrDone[aclSel], st_r.aclRdDone[aclSel],
                  st_r.aclWrDir[aclSel], st_r.aclIdx[aclSel]});
         end
      endcase
   end

   // next state: bus slave, table engines, lookup pipeline
   always_comb
   begin
      st_nxt = st_r;
      word = 32'h0000_0000;
      st_nxt.ack = take;
      if (take && !wbWe)
         st_nxt.rdData = rd;

      // lookup: ram read, then registered attributes
      st_nxt.lkPend = lkGo;
      st_nxt.lkValid = 1'b0;
      if (lkGo)
         st_nxt.lkDa = lkDa;
      if (st_r.lkPend)
      begin
         st_nxt.lkValid = 1'b1;
         st_nxt.lkUseMap = vlanRamRd.fwdOpt;
         st_nxt.lkFwdMap = vlanRamRd.fwdOpt ? vlanRamRd.member : 8'h00;
         st_nxt.lkUntag = vlanRamRd.untag;
         st_nxt.lkPrio = vlanRamRd.prio;
         st_nxt.lkSpanIdx = vlanRamRd.spanIdx;
         st_nxt.lkFid = vlanRamRd.filter_identifier;
         st_nxt.lkHash = stiHashIdx(st_r.lkDa, vlanRamRd.filter_identifier);
      end

      // vlan engine: write completes at issue, read one cycle later
      if (vlanGo)
      begin
         if (st_r.vlanRead)
            st_nxt.vlanRdPend = 1'b1;
         else
            st_nxt.vlanStart = 1'b0;
      end
      if (st_r.vlanRdPend)
      begin
         st_nxt.vlanEntry = vlanRamRd;
         st_nxt.vlanRdPend = 1'b0;
         st_nxt.vlanStart = 1'b0;
      end

      // multicast engine: one cycle per operation
      if (st_r.mcastStart)
      begin
         if (st_r.mcastRead)
            st_nxt.mcastData = mcastRdWord & MCAST_DATA_MASK;
         st_nxt.mcastStart = 1'b0;
      end

      // acl engine: enabled bytes move and the done flag rises in the same cycle
      if (aclBusy)
      begin
         if (!st_r.aclWrDir[st_r.aclPort])
         begin
            for (int i = 0; i < ACL_BYTES; i++)
            begin
               if (aclByteEn[i])
                  st_nxt.aclData[st_r.aclPort][i] = aclRdByte[i];
            end
            st_nxt.aclRdDone[st_r.aclPort] = 1'b1;
         end
         else
            st_nxt.aclWrDone[st_r.aclPort] = 1'b1;
         st_nxt.aclState = ACL_IDLE;
      end

      // software writes; a busy table refuses data and start writes
      if (wrTake)
      begin
         case (wbAdr)
            VLAN_ENTRY0_OFS:
            begin
               word = stiMerge(vlanWord0(st_r.vlanEntry), wbDatWr, wbSel);
               if (!st_r.vlanStart)
               begin
                  st_nxt.vlanEntry.filter_identifier = word[VE0_FID_LSB +: 7];
                  st_nxt.vlanEntry.spanIdx = word[VE0_SPAN_LSB +: 3];
                  st_nxt.vlanEntry.prio = word[VE0_PRIO_LSB +: 3];
                  st_nxt.vlanEntry.fwdOpt = word[VE0_FWDOPT_BIT];
                  st_nxt.vlanEntry.valid = word[VE0_VALID_BIT];
               end
            end
            VLAN_ENTRY1_OFS:
            begin
               if (!st_r.vlanStart && wbSel[0])
                  st_nxt.vlanEntry.untag = wbDatWr[7:0] & PORT_MAP_MASK;
            end
            VLAN_ENTRY2_OFS:
            begin
               if (!st_r.vlanStart && wbSel[0])
                  st_nxt.vlanEntry.member = wbDatWr[7:0] & PORT_MAP_MASK;
            end
            VLAN_INDEX_OFS:
            begin
               word = stiMerge(32'(st_r.vlanIdx), wbDatWr, wbSel);
               if (!st_r.vlanStart)
                  st_nxt.vlanIdx = word[VLAN_IDX_W-1:0];
            end
            VLAN_ACCESS_OFS:
            begin
               if (!st_r.vlanStart && wbSel[0])
               begin
                  st_nxt.vlanRead = wbDatWr[VLAN_READ_BIT];
                  st_nxt.vlanStart = wbDatWr[START_BIT];
               end
            end
            LOOKUP_CTRL_OFS:
            begin
               if (wbSel[0])
                  st_nxt.lookupEn = wbDatWr[LOOKUP_EN_BIT];
            end
            MCAST_CTRL_OFS:
            begin
               if (!st_r.mcastStart && wbSel[0])
               begin
                  st_nxt.mcastIdx = wbDatWr[5:0];
                  st_nxt.mcastRead = wbDatWr[MCAST_READ_BIT];
                  st_nxt.mcastStart = wbDatWr[START_BIT];
               end
            end
            MCAST_DATA_OFS:
            begin
               word = stiMerge(st_r.mcastData, wbDatWr, wbSel);
               if (!st_r.mcastStart)
                  st_nxt.mcastData = word & MCAST_DATA_MASK;
            end
            default:
            begin
               if (aclHit && !(aclBusy && aclSel == st_r.aclPort) && wbSel[0])
               begin
                  if (wbAdr[11:6] == ACL_DATA_OFS[11:6])
                     st_nxt.aclData[aclSel][wbAdr[5:2]] =
                        wbDatWr[7:0] & ACL_BYTE_MASK[wbAdr[5:2]];
                  else if (wbAdr[11:0] == ACL_BE_MSB_OFS)
                     st_nxt.aclBe[aclSel][15:8] = wbDatWr[7:0];
                  else if (wbAdr[11:0] == ACL_BE_LSB_OFS)
                     st_nxt.aclBe[aclSel][7:0] = wbDatWr[7:0];
                  else if (wbAdr[11:0] == ACL_CTRL_OFS && !aclBusy)
                  begin
                     st_nxt.aclIdx[aclSel] = wbDatWr[3:0];
                     st_nxt.aclWrDir[aclSel] = wbDatWr[ACL_WRITE_BIT];
                     st_nxt.aclRdDone[aclSel] = 1'b0;
                     st_nxt.aclWrDone[aclSel] = 1'b0;
                     st_nxt.aclPort = aclSel;
                     st_nxt.aclState = ACL_BUSY;
                  end
               end
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r <= '0;
         st_r.mcastData <= MCAST_DATA_RST;
         st_r.aclBe <= {ACL_PORT_CNT{ACL_BE_RST}};
         st_r.aclState <= ACL_IDLE;
      end
      else
         st_r <= st_nxt;
   end

   // outputs straight from the state register
   assign wbDatRd = st_r.rdData;
   assign wbAck = st_r.ack;
   assign lkValid = st_r.lkValid;
   assign lkUseMap = st_r.lkUseMap;
   assign lkFwdMap = st_r.lkFwdMap;
   assign lkUntag = st_r.lkUntag;
   assign lkPrio = st_r.lkPrio;
   assign lkSpanIdx = st_r.lkSpanIdx;
   assign lkFid = st_r.lkFid;
   assign lkHash = st_r.lkHash;
   assign vlanAware = st_r.lookupEn;

   // helper checks over all acl ports
   logic aclByteCZero;
   logic aclRuleNibbleOk;
   always_comb
   begin
      aclByteCZero = 1'b1;
      aclRuleNibbleOk = 1'b1;
      for (int p = 0; p < ACL_PORT_CNT; p++)
      begin
         if (st_r.aclData[p][ACL_UNUSED_BYTE] != 8'h00)
            aclByteCZero = 1'b0;
         if (st_r.aclData[p][0][7:4] != 4'h0)
            aclRuleNibbleOk = 1'b0;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence s_vlan_issue_wr;
      vlanGo && !st_r.vlanRead;
   endsequence
   sequence s_vlan_issue_rd;
      vlanGo && st_r.vlanRead;
   endsequence

   property p_mcast_mask;
      (st_r.mcastData & ~MCAST_DATA_MASK) == 32'h0000_0000;
   endproperty
   a_mcast_mask: assert property (p_mcast_mask) else $error("multicast reserved bit set");
   property p_lookup_fetch;
      lkReq && st_r.lookupEn |-> ##2 st_r.lkValid;
   endproperty
   a_lookup_fetch: assert property (p_lookup_fetch) else $error("lookup gave no result");
   property p_lookup_gated;
      lkReq && !st_r.lookupEn |-> ##2 !st_r.lkValid;
   endproperty
   a_lookup_gated: assert property (p_lookup_gated) else $error("lookup while disabled");
   property p_option_map;
      st_r.lkValid && !st_r.lkUseMap |-> st_r.lkFwdMap == 8'h00;
   endproperty
   a_option_map: assert property (p_option_map) else $error("map used with option off");
   property p_hash;
      st_r.lkValid |-> st_r.lkHash == stiHashIdx($past(st_r.lkDa), st_r.lkFid);
   endproperty
   a_hash: assert property (p_hash) else $error("hash index mismatch");
   property p_reserved_port;
      st_r.lkValid |-> !st_r.lkUntag[6] && !st_r.lkFwdMap[6];
   endproperty
   a_reserved_port: assert property (p_reserved_port) else $error("reserved port bit set");
   property p_vlan_wr_done;
      s_vlan_issue_wr |=> !st_r.vlanStart;
   endproperty
   a_vlan_wr_done: assert property (p_vlan_wr_done) else $error("vlan write not cleared");
   property p_vlan_rd_done;
      s_vlan_issue_rd |=> st_r.vlanRdPend ##1 (!st_r.vlanStart
         && st_r.vlanEntry == $past(vlanRamRd));
   endproperty
   a_vlan_rd_done: assert property (p_vlan_rd_done) else $error("vlan read wrong");
   property p_vlan_hold;
      st_r.vlanStart && !st_r.vlanRdPend |=> $stable(st_r.vlanEntry);
   endproperty
   a_vlan_hold: assert property (p_vlan_hold) else $error("vlan data moved while busy");
   property p_byte_c;
      aclByteCZero;
   endproperty
   a_byte_c: assert property (p_byte_c) else $error("unused acl byte nonzero");
   property p_rule_nibble;
      aclRuleNibbleOk;
   endproperty
   a_rule_nibble: assert property (p_rule_nibble) else $error("rule byte reserved set");
   property p_acl_rd;
      aclBusy && !st_r.aclWrDir[st_r.aclPort] |=> !aclBusy
         && st_r.aclRdDone[$past(st_r.aclPort)];
   endproperty
   a_acl_rd: assert property (p_acl_rd) else $error("acl read not done");
   property p_acl_wr;
      aclBusy && st_r.aclWrDir[st_r.aclPort] |=> !aclBusy
         && st_r.aclWrDone[$past(st_r.aclPort)];
   endproperty
   a_acl_wr: assert property (p_acl_wr) else $error("acl write not done");
endmodule

/* sti_pkg.sv */
// constants, register map and state types of the switch table access block
package sti_pkg;
   // register byte offsets on the management bus
   localparam logic [15:0] VLAN_ENTRY0_OFS = 16'h0400;
   localparam logic [15:0] VLAN_ENTRY1_OFS = 16'h0404;
   localparam logic [15:0] VLAN_ENTRY2_OFS = 16'h0408;
   localparam logic [15:0] VLAN_INDEX_OFS = 16'h040c;
   localparam logic [15:0] VLAN_ACCESS_OFS = 16'h0410;
   localparam logic [15:0] LOOKUP_CTRL_OFS = 16'h0414;
   localparam logic [15:0] MCAST_CTRL_OFS = 16'h0418;
   localparam logic [15:0] MCAST_DATA_OFS = 16'h0424;
   // per-port access control list range: port n sits at n * 0x1000
   localparam logic [11:0] ACL_DATA_OFS = 12'h600;
   localparam logic [11:0] ACL_BE_MSB_OFS = 12'h640;
   localparam logic [11:0] ACL_BE_LSB_OFS = 12'h644;
   localparam logic [11:0] ACL_CTRL_OFS = 12'h648;
   // control bit positions
   localparam int START_BIT = 7;
   localparam int VLAN_READ_BIT = 0;
   localparam int MCAST_READ_BIT = 6;
   localparam int LOOKUP_EN_BIT = 0;
   localparam int ACL_WRITE_BIT = 4;
   localparam int ACL_RD_DONE_BIT = 5;
   localparam int ACL_WR_DONE_BIT = 6;
   // vlan entry 0 field positions
   localparam int VE0_FID_LSB = 0;
   localparam int VE0_SPAN_LSB = 8;
   localparam int VE0_PRIO_LSB = 12;
   localparam int VE0_FWDOPT_BIT = 16;
   localparam int VE0_VALID_BIT = 17;
   // masks and reset values
   localparam logic [31:0] MCAST_DATA_MASK = 32'hc000_004f;
   localparam logic [31:0] MCAST_DATA_RST = 32'h0000_0000;
   localparam logic [7:0] PORT_MAP_MASK = 8'hbf;
   localparam logic [15:0] ACL_BE_RST = 16'h0000;
   localparam logic [15:0][7:0] ACL_BYTE_MASK = {8'hff, 8'hff, 8'h7f, 8'h00, 8'he0, 8'hff,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h0f};
   // table geometry
   localparam int VLAN_DEPTH = 4096;
   localparam int VLAN_IDX_W = 12;
   localparam int VLAN_W = 31;
   localparam int MCAST_ENTRIES = 64;
   localparam int ACL_PORT_CNT = 5;
   localparam int ACL_ENTRIES = 16;
   localparam int ACL_BYTES = 16;
   localparam int ACL_UNUSED_BYTE = 12;

   typedef enum logic {ACL_IDLE = 1'b0, ACL_BUSY = 1'b1} sti_acl_state_t;

   typedef struct packed {
      logic valid;
      logic fwdOpt;
      logic [2:0] prio;
      logic [2:0] spanIdx;
      logic [6:0] filter_identifier;
      logic [7:0] untag;
      logic [7:0] member;
   } sti_vlan_t;

   typedef struct packed {
      logic ack;
      logic [31:0] rdData;
      sti_vlan_t vlanEntry;
      logic [VLAN_IDX_W-1:0] vlanIdx;
      logic vlanStart;
      logic vlanRead;
      logic vlanRdPend;
      logic lookupEn;
      logic [31:0] mcastData;
      logic [5:0] mcastIdx;
      logic mcastStart;
      logic mcastRead;
      logic [ACL_PORT_CNT-1:0][ACL_BYTES-1:0][7:0] aclData;
      logic [ACL_PORT_CNT-1:0][15:0] aclBe;
      logic [ACL_PORT_CNT-1:0][3:0] aclIdx;
      logic [ACL_PORT_CNT-1:0] aclWrDir;
      logic [ACL_PORT_CNT-1:0] aclRdDone;
      logic [ACL_PORT_CNT-1:0] aclWrDone;
      sti_acl_state_t aclState;
      logic [2:0] aclPort;
      logic lkPend;
      logic [47:0] lkDa;
      logic lkValid;
      logic lkUseMap;
      logic [7:0] lkFwdMap;
      logic [7:0] lkUntag;
      logic [2:0] lkPrio;
      logic [2:0] lkSpanIdx;
      logic [6:0] lkFid;
      logic [11:0] lkHash;
   } sti_state_t;

   // byte-lane merge of a bus write into an old register value
   function automatic logic [31:0] stiMerge(input logic [31:0] old, input logic [31:0] wr,
                                            input logic [3:0] sel);
      logic [31:0] m;
      for (int b = 0; b < 4; b++)
         m[b*8 +: 8] = {8{sel[b]}};
      return (old & ~m) | (wr & m);
   endfunction

   // address table index from filter id and destination address
   function automatic logic [11:0] stiHashIdx(input logic [47:0] da, input logic [6:0] filter_identifier);
      return da[11:0] ^ da[23:12] ^ da[35:24] ^ da[47:36] ^ {5'h00, filter_identifier};
   endfunction
endpackage

/* sti_vlan_ram.sv */
// single-port vlan table storage with registered read
`timescale 1ns/1ps
module sti_vlan_ram
#(
   parameter int DEPTH = 4096,
   parameter int AW = 12,
   parameter int DW = 31
)(
   input wire logic clk_sys,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wrData,
   output logic [DW-1:0] rdData
);
   logic [DW-1:0] mem [DEPTH];

   // one access per cycle, read data one cycle later
   always_ff @(posedge clk_sys)
   begin
      if (we)
         mem[addr] <= wrData;
      rdData <= mem[addr];
   end
endmodule

/* sti_table_access_tb_top.sv */
// self-checking bench for the switch table access block
`timescale 1ns/1ps
module sti_table_access_tb_top
   import sti_pkg::*;
;
   logic clk_sys, rst_n, wbCyc, wbStb, wbWe, wbAck, lkReq, lkValid, lkUseMap, vlanAware;
   logic [15:0] wbAdr;
   logic [3:0] wbSel;
   logic [31:0] wbDatWr, wbDatRd, rdVal;
   logic [VLAN_IDX_W-1:0] lkVid;
   logic [47:0] lkDa;
   logic [7:0] lkFwdMap, lkUntag, expB;
   logic [2:0] lkPrio, lkSpanIdx;
   logic [6:0] lkFid;
   logic [11:0] lkHash;
   logic [15:0] aclBase;
   int n_errors, num_checks;

   sti_table_access i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb),
      .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatWr(wbDatWr), .wbDatRd(wbDatRd),
      .wbAck(wbAck), .lkReq(lkReq), .lkVid(lkVid), .lkDa(lkDa), .lkValid(lkValid),
      .lkUseMap(lkUseMap), .lkFwdMap(lkFwdMap), .lkUntag(lkUntag), .lkPrio(lkPrio),
      .lkSpanIdx(lkSpanIdx), .lkFid(lkFid), .lkHash(lkHash), .vlanAware(vlanAware));

   // free-running 50 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic final_report();
      if (n_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one classic wishbone cycle, held until ack is sampled high
   task automatic xfer(input logic we, input logic [15:0] adr, input logic [31:0] dat);
      int n;
      @(posedge clk_sys);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbSel <= 4'hf;
      wbAdr <= adr;
      wbDatWr <= dat;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end while (wbAck !== 1'b1 && n < 50);
      rdVal = wbDatRd;
      check("ack", 1, wbAck);
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
   endtask

   task automatic wr(input logic [15:0] adr, input logic [31:0] dat);
      xfer(1'b1, adr, dat);
   endtask

   task automatic rd(input logic [15:0] adr);
      xfer(1'b0, adr, 32'h0000_0000);
   endtask

   // reread a status bit until it reaches the wanted level
   task automatic poll(input logic [15:0] adr, input int b, input logic val);
      rd(adr);
      for (int k = 0; k < 20 && rdVal[b] !== val; k++)
         rd(adr);
      check("status bit", val, rdVal[b]);
   endtask

   // hang guard
   initial
   begin
      #400000;
      n_errors++;
      final_report();
   end

   // main sequence
   initial
   begin
      {rst_n, wbCyc, wbStb, wbWe, lkReq} = 5'h00;
      wbSel = 4'hf;
      {wbAdr, wbDatWr, lkVid, lkDa} = '0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(MCAST_DATA_OFS);
      check("mcast reset", 32'h0000_0000, rdVal);
      wr(MCAST_DATA_OFS, 32'hffff_ffff);
      rd(MCAST_DATA_OFS);
      check("mcast mask", 32'hc000_004f, rdVal);
      wr(MCAST_DATA_OFS, 32'h0000_004a);
      wr(MCAST_CTRL_OFS, 32'h0000_0085);
      poll(MCAST_CTRL_OFS, 7, 1'b0);
      wr(MCAST_DATA_OFS, 32'h0000_0000);
      wr(MCAST_CTRL_OFS, 32'h0000_00c5);
      poll(MCAST_CTRL_OFS, 7, 1'b0);
      rd(MCAST_DATA_OFS);
      check("mcast entry", 32'h0000_004a, rdVal);
      // vlan entry at the top index, written then read back
      wr(VLAN_ENTRY0_OFS, 32'h0003_5355);
      wr(VLAN_ENTRY1_OFS, 32'h0000_00ff);
      wr(VLAN_ENTRY2_OFS, 32'h0000_00c3);
      wr(VLAN_INDEX_OFS, 32'h0000_0fff);
      wr(VLAN_ACCESS_OFS, 32'h0000_0080);
      poll(VLAN_ACCESS_OFS, 7, 1'b0);
      wr(VLAN_ENTRY0_OFS, 32'h0000_0000);
      wr(VLAN_ENTRY1_OFS, 32'h0000_0000);
      wr(VLAN_ENTRY2_OFS, 32'h0000_0000);
      wr(VLAN_ACCESS_OFS, 32'h0000_0081);
      poll(VLAN_ACCESS_OFS, 7, 1'b0);
      rd(VLAN_ENTRY0_OFS);
      check("vlan entry0", 32'h0003_5355, rdVal);
      rd(VLAN_ENTRY1_OFS);
      check("vlan untag", 32'h0000_00bf, rdVal);
      rd(VLAN_ENTRY2_OFS);
      check("vlan member", 32'h0000_0083, rdVal);
      // a request while vlan-aware mode is off is ignored
      @(posedge clk_sys);
      lkReq <= 1'b1;
      lkVid <= 12'hfff;
      lkDa <= 48'h1234_5678_9abc;
      @(posedge clk_sys);
      lkReq <= 1'b0;
      @(posedge clk_sys);
      #1;
      check("lk gated", 0, lkValid);
      // lookup of that entry once vlan-aware mode is on
      wr(LOOKUP_CTRL_OFS, 32'h0000_0001);
      check("aware", 1, vlanAware);
      @(posedge clk_sys);
      lkReq <= 1'b1;
      @(posedge clk_sys);
      lkReq <= 1'b0;
      @(posedge clk_sys);
      #1;
      check("lk valid", 1, lkValid);
      check("lk usemap", 1, lkUseMap);
      check("lk fwdmap", 32'h83, lkFwdMap);
      check("lk untag", 32'hbf, lkUntag);
      check("lk fields", 32'h5355, {lkPrio, 1'b0, lkSpanIdx, 1'b0, lkFid});
      check("lk hash", 32'h0abc ^ 32'h0789 ^ 32'h0456 ^ 32'h0123 ^ 32'h0055, lkHash);
      // lookups every cycle stall a vlan write; entry registers stay locked
      @(posedge clk_sys);
      lkReq <= 1'b1;
      wr(VLAN_ACCESS_OFS, 32'h0000_0080);
      wr(VLAN_ENTRY1_OFS, 32'h0000_0000);
      rd(VLAN_ENTRY1_OFS);
      check("vlan locked", 32'h0000_00bf, rdVal);
      rd(VLAN_ACCESS_OFS);
      check("vlan stalled", 32'h0000_0080, rdVal);
      @(posedge clk_sys);
      lkReq <= 1'b0;
      poll(VLAN_ACCESS_OFS, 7, 1'b0);
      rd(16'h0500);
      check("unmapped", 32'h0000_0000, rdVal);
      // acl port 1: write all ones, clear data, read back with byte 0 disabled
      aclBase = 16'h1000;
      for (int i = 0; i < 16; i++)
         wr(aclBase + ACL_DATA_OFS + 16'(4 * i), 32'h0000_00ff);
      wr(aclBase + ACL_BE_MSB_OFS, 32'h0000_00ff);
      wr(aclBase + ACL_BE_LSB_OFS, 32'h0000_00ff);
      wr(aclBase + ACL_CTRL_OFS, 32'h0000_0013);
      poll(aclBase + ACL_CTRL_OFS, 6, 1'b1);
      for (int i = 0; i < 16; i++)
         wr(aclBase + ACL_DATA_OFS + 16'(4 * i), 32'h0000_0000);
      wr(aclBase + ACL_BE_MSB_OFS, 32'h0000_007f);
      wr(aclBase + ACL_CTRL_OFS, 32'h0000_0003);
      poll(aclBase + ACL_CTRL_OFS, 5, 1'b1);
      for (int i = 0; i < 16; i++)
      begin
         expB = (i == 0 || i == 12) ? 8'h00 : (i == 1) ? 8'h3f : (i == 11) ? 8'he0 :
            (i == 13) ? 8'h7f : 8'hff;
         rd(aclBase + ACL_DATA_OFS + 16'(4 * i));
         check("acl byte", {24'h0, expB}, rdVal);
      end
      final_report();
   end
endmodule
